//--- hdl/asc_chan_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module asc_chan_fifo (
  // System
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // Control
  input  wire logic        flush,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [23:0] din,
  // State
  output logic      [23:0] dout,
  output logic      [1:0]  level,
  output logic             ready
);
  logic [23:0] slot1;

  // When full, a new sample pushes out the oldest so the freshest two remain
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dout  <= 24'h000000;
      slot1 <= 24'h000000;
      level <= 2'h0;
    end else if (flush) begin
      // A sample landing with the flush is kept, not lost
      level <= push ? 2'h1 : 2'h0;
      if (push) begin
        dout <= din;
      end
    end else begin
      case (level)
        2'h0: begin
          if (push) begin
            dout  <= din;
            level <= 2'h1;
          end
        end
        2'h1: begin
          if (push && pop) begin
            dout <= din;
          end else if (push) begin
            slot1 <= din;
            level <= 2'h2;
          end else if (pop) begin
            level <= 2'h0;
          end
        end
        default: begin
          if (push) begin
            dout  <= slot1;
            slot1 <= din;
          end else if (pop) begin
            dout  <= slot1;
            level <= 2'h1;
          end
        end
      endcase
    end
  end

  assign ready = (level != 2'h0);

  flag_hold_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    (level == 2'h2 && pop && !push && !flush) |=> (ready && level == 2'h1))
    else $error("ready flag dropped with one sample left");
  depth_two_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    (level == 2'h2 && push && !flush) |=> (level == 2'h2 && dout == $past(slot1)))
    else $error("fifo exceeded two slots");
endmodule : asc_chan_fifo
`default_nettype wire

//--- hdl/asc_pkg.sv
// Notes on behaviour
// - Samples are 24-bit two's complement, saturating at the most positive and most negative codes.
// - Each channel buffers up to two samples; a slot frees when its sample is read.
// - A channel ready flag stays set until both buffered samples are read.
// - Host recovers by strobing sync/reset (flush buffers) or reading two packets back to back.
// - In level format a narrow ready blip may follow the first set read after a pause.
// - Every command is answered in the frame after the one that carried it.
// - The all-zero command changes nothing and answers with the status word.
// - Any unknown command acts as no-operation and answers with the status word.
// - Reset command is latched at frame end, then all registers return to defaults.
// - Completed reset frame answers FF28h; an incomplete one does not reset and answers 0011h.
// - Standby command is latched at frame end, enters standby, and is echoed.
// - Standby while already in standby has no effect.
// - Wakeup returns to conversion mode and is echoed; no effect when already converting.
// - After lock only no-op, register read and unlock act; lock is echoed.
// - Conversion data still flow while locked, in every frame not taken by a multi register read.
// - Unlock releases the lock and is echoed; both printed encodings are accepted.
// - Register read is prefix 101, 6-bit start address, 7-bit count minus one.
// - Single register read answers with the register contents themselves.
// - Multi register read answers header 111/address/count, then registers ascending.
// - Register write is prefix 011; answer is 010, address, registers written minus one.
// - Command and register words carry 16 bits MSB aligned, zero padded to 16/24/32.
// - Each frame starts with a command; first output word answers the previous command.
package asc_pkg;
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          READY_PULSE_NS  = 40;
  localparam int          READY_PULSE_CYC = (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NUM_CH          = 8;
  localparam int          RAW_W           = 26;
  localparam int          MEM_WORDS       = 16;
  localparam logic [15:0] CMD_NULL        = 16'h0000;
  localparam logic [15:0] CMD_RESET       = 16'h0011;
  localparam logic [15:0] CMD_STANDBY     = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP      = 16'h0033;
  localparam logic [15:0] CMD_LOCK        = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK_A    = 16'h0655;
  localparam logic [15:0] CMD_UNLOCK_B    = 16'h0666;
  localparam logic [15:0] RESP_RESET_OK   = 16'hFF28;
  localparam logic [15:0] RESP_RESET_CUT  = 16'h0011;
  localparam logic [2:0]  PFX_READ_REGISTERS_CMD        = 3'h5;
  localparam logic [2:0]  PFX_READ_REGISTERS_CMD_HDR    = 3'h7;
  localparam logic [2:0]  PFX_WRITE_REGISTERS_CMD        = 3'h3;
  localparam logic [2:0]  PFX_WRITE_REGISTERS_CMD_ACK    = 3'h2;
  localparam logic [23:0] CODE_MAX        = 24'h7FFFFF;
  localparam logic [23:0] CODE_MIN        = 24'h800000;
  localparam logic [7:0]  FULL_FRAME_WORDS = 8'h0A;
  localparam logic [5:0]  ADDR_ID         = 6'h00;
  localparam logic [5:0]  ADDR_STATUS     = 6'h01;
  localparam logic [5:0]  ADDR_MODE       = 6'h02;
  localparam logic [5:0]  ADDR_MEM_BASE   = 6'h03;
  localparam logic [15:0] MODE_RST        = 16'h0510;
  localparam int          MODE_WL_LSB     = 8;
  localparam int          MODE_FMT_BIT    = 0;
  localparam int          MODE_RESET_BIT  = 10;
  localparam logic [1:0]  WL_16           = 2'h0;
  localparam logic [1:0]  WL_24           = 2'h1;
  localparam logic [1:0]  WL_32_SEXT      = 2'h3;
  localparam logic [3:0]  SYNC_IDLE       = 4'h9;
  localparam logic [1:0]  LOC_ENABLE      = 2'h0;
  localparam logic [1:0]  LOC_STATUS      = 2'h1;
  localparam logic [7:0]  ENABLE_RST      = 8'hFF;
  typedef enum logic [2:0] {
    CK_NULL, CK_RESET, CK_STANDBY, CK_WAKEUP, CK_LOCK, CK_UNLOCK, CK_READ_REGISTERS_CMD, CK_WRITE_REGISTERS_CMD
  } asc_cmd_t;
endpackage : asc_pkg

//--- hdl/asc_spi_cmd.sv
`timescale 1ns/100ps
`default_nettype none
module asc_spi_cmd #(
  parameter logic [15:0] ID_VALUE = 16'h2A00 // Arbitrary identity value
) (
  // System
  input  wire logic                      CLK,
  input  wire logic                      SYS_RST,
  // Serial link pins
  input  wire logic                      CS_N,
  input  wire logic                      SCLK,
  input  wire logic                      DIN,
  output logic                           DOUT,
  output logic                           DATA_READY_N,
  input  wire logic                      SYNC_RST_N,
  // Conversion core
  input  wire logic                      SAMPLE_VALID,
  input  wire logic [2:0]                SAMPLE_CHAN,
  input  wire logic [asc_pkg::RAW_W-1:0] SAMPLE_RAW,
  output logic                           STANDBY,
  output logic                           RESYNC,
  output logic                           SOFT_RESET,
  // Local register port
  input  wire logic [1:0]                LOC_ADDR,
  input  wire logic [15:0]               LOC_WDATA,
  input  wire logic                      LOC_WR,
  input  wire logic                      LOC_RD,
  output logic      [15:0]               LOC_RDATA
);
  import asc_pkg::*;

  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  prev;
  logic [15:0] mode;
  logic [15:0] mem [MEM_WORDS];
  logic        locked;
  logic [7:0]  enable_mask;
  logic [1:0]  wl_frame;
  logic [5:0]  in_bit;
  logic [7:0]  in_word;
  logic [15:0] in_sr;
  logic [15:0] cmd;
  logic [7:0]  wr_count;
  logic [5:0]  out_bit;
  logic [7:0]  out_word;
  logic [31:0] out_sr;
  logic        data_frame;
  logic [15:0] resp;
  logic        rr_pend;
  logic [5:0]  rr_addr;
  logic [6:0]  rr_n;
  logic        blip;
  logic [7:0]  pulse_cnt;
  logic [23:0] fifo_dout [NUM_CH];
  logic [1:0]  fifo_level [NUM_CH];
  logic [7:0]  ready;
  logic [7:0]  push;
  logic [7:0]  pop;
  logic [23:0] clip_val;
  logic [31:0] next_out;

  // Pins cross in through two flops; edges are found on the second stage only
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
      prev  <= SYNC_IDLE;
    end else begin
      sync1 <= {SYNC_RST_N, DIN, SCLK, CS_N};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  wire logic       frame_start = !sync2[0] && prev[0];
  wire logic       frame_end   = sync2[0] && !prev[0];
  wire logic       sclk_rise   = sync2[1] && !prev[1] && !sync2[0];
  wire logic       sclk_fall   = !sync2[1] && prev[1] && !sync2[0];
  wire logic       din_s       = sync2[2];
  wire logic       sync_fall   = !sync2[3] && prev[3];
  wire logic [5:0] wbits       = (wl_frame == WL_16) ? 6'd16 : (wl_frame == WL_24) ? 6'd24 : 6'd32;
  wire logic       fmt_pulse   = mode[MODE_FMT_BIT];
  wire logic       standby_now = STANDBY;
  wire logic [15:0] status_word = {locked, 4'h0, mode[MODE_RESET_BIT], mode[MODE_WL_LSB+1:MODE_WL_LSB], ready};

  function automatic asc_cmd_t decode(input logic [15:0] c, input logic lk);
    asc_cmd_t k;
    k = CK_NULL;
    if (c[15:13] == PFX_READ_REGISTERS_CMD) begin
      k = CK_READ_REGISTERS_CMD;
    end else if (c == CMD_UNLOCK_A || c == CMD_UNLOCK_B) begin
      k = CK_UNLOCK;
    end else if (!lk) begin
      if (c[15:13] == PFX_WRITE_REGISTERS_CMD) begin
        k = CK_WRITE_REGISTERS_CMD;
      end else if (c == CMD_RESET) begin
        k = CK_RESET;
      end else if (c == CMD_STANDBY) begin
        k = CK_STANDBY;
      end else if (c == CMD_WAKEUP) begin
        k = CK_WAKEUP;
      end else if (c == CMD_LOCK) begin
        k = CK_LOCK;
      end
    end
    return k;
  endfunction : decode

  function automatic logic [15:0] reg_read(input logic [5:0] a);
    logic [15:0] v;
    logic [5:0]  idx;
    v   = 16'h0000;
    idx = a - ADDR_MEM_BASE;
    if (a == ADDR_ID) begin
      v = ID_VALUE;
    end else if (a == ADDR_STATUS) begin
      v = status_word;
    end else if (a == ADDR_MODE) begin
      v = mode;
    end else if (a >= ADDR_MEM_BASE && idx < 6'(MEM_WORDS)) begin
      v = mem[idx[3:0]];
    end
    return v;
  endfunction : reg_read

  function automatic logic [23:0] clip(input logic [RAW_W-1:0] r);
    logic [23:0] v;
    v = r[23:0];
    if ($signed(r) > $signed({{(RAW_W-24){1'b0}}, CODE_MAX})) begin
      v = CODE_MAX;
    end else if ($signed(r) < $signed({{(RAW_W-24){1'b1}}, CODE_MIN})) begin
      v = CODE_MIN;
    end
    return v;
  endfunction : clip

  asc_cmd_t   kind;
  logic       complete;
  logic       do_sreset;
  logic       word_done;
  logic [15:0] word_in;
  logic [5:0] wr_addr;
  logic       wr_hit;

  assign kind      = decode(cmd, locked);
  assign complete  = (in_word >= FULL_FRAME_WORDS);
  assign do_sreset = frame_end && kind == CK_RESET && complete;
  assign word_done = sclk_fall && in_bit == 6'd15;
  assign word_in   = {in_sr[14:0], din_s};
  assign wr_addr   = cmd[12:7] + in_word[5:0] - 6'd1;
  assign wr_hit    = word_done && in_word != 8'h00 && in_word <= {1'b0, cmd[6:0]} + 8'd1 && kind == CK_WRITE_REGISTERS_CMD;
  assign clip_val  = clip(SAMPLE_RAW);

  // Input shifter; word length is frozen for the whole frame
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      in_bit   <= 6'h00;
      in_word  <= 8'h00;
      in_sr    <= 16'h0000;
      wl_frame <= WL_24;
    end else if (frame_start) begin
      in_bit   <= 6'h00;
      in_word  <= 8'h00;
      wl_frame <= mode[MODE_WL_LSB+1:MODE_WL_LSB];
    end else if (sclk_fall) begin
      in_sr <= word_in;
      if (in_bit == wbits - 6'd1) begin
        in_bit <= 6'h00;
        if (in_word != 8'hFF) begin
          in_word <= in_word + 8'd1;
        end
      end else begin
        in_bit <= in_bit + 6'd1;
      end
    end
  end

  // Command word is the first 16 bits of a frame, padding ignored
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd <= CMD_NULL;
    end else if (frame_start) begin
      cmd <= CMD_NULL;
    end else if (word_done && in_word == 8'h00) begin
      cmd <= word_in;
    end
  end

  // Register words are written as they arrive, so a later error cannot undo them
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode     <= MODE_RST;
      wr_count <= 8'h00;
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (do_sreset) begin
      mode <= MODE_RST;
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (frame_start) begin
      wr_count <= 8'h00;
    end else if (wr_hit) begin
      if (wr_addr == ADDR_MODE) begin
        mode     <= word_in;
        wr_count <= wr_count + 8'd1;
      end else if (wr_addr >= ADDR_MEM_BASE && wr_addr < ADDR_MEM_BASE + 6'(MEM_WORDS)) begin
        mem[4'(wr_addr - ADDR_MEM_BASE)] <= word_in;
        wr_count <= wr_count + 8'd1;
      end
    end
  end

  // Lock and standby change only once the frame is over
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      locked  <= 1'b0;
      STANDBY <= 1'b0;
    end else if (do_sreset) begin
      locked  <= 1'b0;
      STANDBY <= 1'b0;
    end else if (frame_end) begin
      case (kind)
        CK_LOCK:    locked  <= 1'b1;
        CK_UNLOCK:  locked  <= 1'b0;
        CK_STANDBY: STANDBY <= 1'b1;
        CK_WAKEUP:  STANDBY <= 1'b0;
        default:    locked  <= locked;
      endcase
    end
  end

  // Answer for the next frame
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      resp    <= CMD_NULL;
      rr_pend <= 1'b0;
      rr_addr <= 6'h00;
      rr_n    <= 7'h00;
    end else if (frame_end) begin
      rr_pend <= 1'b0;
      case (kind)
        CK_RESET: resp <= complete ? RESP_RESET_OK : RESP_RESET_CUT;
        CK_STANDBY, CK_WAKEUP, CK_LOCK, CK_UNLOCK: resp <= cmd;
        CK_READ_REGISTERS_CMD: begin
          rr_addr <= cmd[12:7];
          rr_n    <= cmd[6:0];
          if (cmd[6:0] == 7'h00) begin
            resp <= reg_read(cmd[12:7]);
          end else begin
            resp    <= {PFX_READ_REGISTERS_CMD_HDR, cmd[12:0]};
            rr_pend <= 1'b1;
          end
        end
        CK_WRITE_REGISTERS_CMD: resp <= {PFX_WRITE_REGISTERS_CMD_ACK, cmd[12:7], 7'(wr_count - 8'd1)};
        default: resp <= status_word;
      endcase
    end
  end

  // Output word selection
  always_comb begin
    logic [15:0] w16;
    logic [23:0] d;
    logic [7:0]  k;
    w16      = 16'h0000;
    d        = 24'h000000;
    k        = out_word - 8'd1;
    next_out = 32'h00000000;
    if (out_word == 8'h00) begin
      next_out = {resp, 16'h0000};
    end else if (rr_pend) begin
      if (k <= {1'b0, rr_n}) begin
        w16      = reg_read(rr_addr + k[5:0]);
        next_out = {w16, 16'h0000};
      end
    end else if (data_frame && out_word <= 8'(NUM_CH)) begin
      d = fifo_dout[k[2:0]];
      case (wl_frame)
        WL_16:      next_out = {d[23:8], 16'h0000};
        WL_32_SEXT: next_out = {{8{d[23]}}, d};
        default:    next_out = {d, 8'h00};
      endcase
    end
  end

  // Output shifter; a new word is loaded on the first rising edge of each word
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_bit    <= 6'h00;
      out_word   <= 8'h00;
      out_sr     <= 32'h00000000;
      data_frame <= 1'b0;
    end else if (frame_start) begin
      out_bit    <= 6'h00;
      out_word   <= 8'h00;
      out_sr     <= 32'h00000000;
      data_frame <= (|ready) && !rr_pend;
    end else if (sclk_rise) begin
      out_sr <= (out_bit == 6'h00) ? next_out : {out_sr[30:0], 1'b0};
      if (out_bit == wbits - 6'd1) begin
        out_bit <= 6'h00;
        if (out_word != 8'hFF) begin
          out_word <= out_word + 8'd1;
        end
      end else begin
        out_bit <= out_bit + 6'd1;
      end
    end
  end

  assign DOUT = out_sr[31];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign push[ch] = SAMPLE_VALID && SAMPLE_CHAN == 3'(ch) && enable_mask[ch] && !standby_now;
      assign pop[ch]  = sclk_rise && out_bit == 6'h00 && data_frame && !rr_pend &&
                        out_word == 8'(ch + 1) && ready[ch];
      asc_chan_fifo u_fifo (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .flush   (sync_fall || do_sreset),
        .push    (push[ch]),
        .pop     (pop[ch]),
        .din     (clip_val),
        .dout    (fifo_dout[ch]),
        .level   (fifo_level[ch]),
        .ready   (ready[ch])
      );
    end
  endgenerate

  // In level format, a read that leaves a second set behind releases the ready line for one cycle
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      blip         <= 1'b0;
      pulse_cnt    <= 8'h00;
      DATA_READY_N <= 1'b1;
      RESYNC       <= 1'b0;
      SOFT_RESET   <= 1'b0;
    end else begin
      blip       <= pop[NUM_CH-1] && fifo_level[NUM_CH-1] == 2'h2;
      RESYNC     <= sync_fall;
      SOFT_RESET <= do_sreset;
      if (push[NUM_CH-1]) begin
        pulse_cnt <= 8'(READY_PULSE_CYC);
      end else if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'd1;
      end
      DATA_READY_N <= fmt_pulse ? (pulse_cnt == 8'h00) : (!(|ready) || blip);
    end
  end

  // Local register port
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      enable_mask <= ENABLE_RST;
      LOC_RDATA   <= 16'h0000;
    end else begin
      if (LOC_WR && LOC_ADDR == LOC_ENABLE) begin
        enable_mask <= LOC_WDATA[7:0];
      end
      if (LOC_RD && LOC_ADDR == LOC_ENABLE) begin
        LOC_RDATA <= {8'h00, enable_mask};
      end else if (LOC_RD && LOC_ADDR == LOC_STATUS) begin
        LOC_RDATA <= {STANDBY, locked, 6'h00, ready};
      end else begin
        LOC_RDATA <= 16'h0000;
      end
    end
  end

  logic        complete_q;
  logic [15:0] single_q;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      complete_q <= 1'b0;
      single_q   <= 16'h0000;
    end else begin
      complete_q <= complete;
      single_q   <= reg_read(cmd[12:7]);
    end
  end

  clip_pos_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    ($signed(SAMPLE_RAW) > $signed({{(RAW_W-24){1'b0}}, CODE_MAX})) |-> clip_val == CODE_MAX)
    else $error("positive overrange not clipped");
  clip_neg_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    ($signed(SAMPLE_RAW) < $signed({{(RAW_W-24){1'b1}}, CODE_MIN})) |-> clip_val == CODE_MIN)
    else $error("negative overrange not clipped");
  resync_flush_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    (sync_fall && push == 8'h00) |=> (ready == 8'h00 && RESYNC))
    else $error("sync strobe did not empty buffers");
  null_status_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    (frame_end && cmd == CMD_NULL) |=> resp == $past(status_word))
    else $error("null answer is not status");
  reset_ack_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    (frame_end && kind == CK_RESET) |=> (resp == (complete_q ? RESP_RESET_OK : RESP_RESET_CUT)))
    else $error("reset answer wrong");
  reset_mode_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    do_sreset |=> (mode == MODE_RST && !locked && SOFT_RESET))
    else $error("reset frame did not restore defaults");
  lock_ignore_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    (frame_end && locked && cmd == CMD_STANDBY) |=> $stable(STANDBY) && resp == $past(status_word))
    else $error("locked device acted on standby");
  read_registers_cmd_single_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    (frame_end && kind == CK_READ_REGISTERS_CMD && cmd[6:0] == 7'h00) |=> (resp == single_q && !rr_pend))
    else $error("single read answer wrong");
endmodule : asc_spi_cmd
`default_nettype wire

//--- tb/asc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module asc_host_model (
  // System
  input  wire logic CLK,
  // Serial link
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  logic [31:0] rx [0:9];

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // Word length stays at the reset value of 24
  task automatic frame(input logic [15:0] cmd, input logic [15:0] dat, input int nw);
    logic [31:0] w;
    @(posedge CLK) cs_n <= 1'b0;
    repeat (8) @(posedge CLK);
    for (int i = 0; i < nw; i++) begin
      w = (i == 0) ? {cmd, 16'h0000} : (i == 1) ? {dat, 16'h0000} : 32'h0;
      rx[i] = 32'h0;
      for (int b = 0; b < 24; b++) begin
        // DIN moves mid-low, well clear of the sampling fall
        repeat (8) @(posedge CLK);
        din <= w[31-b];
        repeat (8) @(posedge CLK);
        sclk <= 1'b1;
        repeat (16) @(posedge CLK);
        rx[i] = {rx[i][30:0], dout};
        sclk <= 1'b0;
      end
    end
    repeat (8) @(posedge CLK);
    cs_n <= 1'b1;
    // Released line shows no stale bit
    din  <= ~din;
    repeat (8) @(posedge CLK);
  endtask : frame
endmodule : asc_host_model
`default_nettype wire

//--- tb/asc_spi_cmd_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module asc_spi_cmd_tb_top;
  import asc_pkg::*;
  logic             clk, sys_rst, cs_n, sclk, din, dout, ready_n, sync_n;
  logic             s_valid, standby, resync, soft_rst, loc_wr, loc_rd;
  logic [2:0]       s_chan;
  logic [RAW_W-1:0] s_raw;
  logic [1:0]       loc_addr;
  logic [15:0]      loc_wdata, loc_rdata;
  int               n_errors = 0, tests_run = 0, cycles = 0, n_resync = 0, n_soft = 0;
  logic [25:0]      raws [0:7] = '{26'h0FFFFFF, 26'h3000000, 26'h0000001, 26'h3FFFFFF,
                                   26'h07FFFFF, 26'h3800000, 26'h0, 26'h0123456};
  logic [23:0]      codes [0:3] = '{24'h7FFFFF, 24'h800000, 24'h000001, 24'hFFFFFF};

  asc_spi_cmd asc_spi_cmd_inst (.CLK(clk), .SYS_RST(sys_rst), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .DOUT(dout), .DATA_READY_N(ready_n), .SYNC_RST_N(sync_n), .SAMPLE_VALID(s_valid),
    .SAMPLE_CHAN(s_chan), .SAMPLE_RAW(s_raw), .STANDBY(standby), .RESYNC(resync),
    .SOFT_RESET(soft_rst), .LOC_ADDR(loc_addr), .LOC_WDATA(loc_wdata), .LOC_WR(loc_wr),
    .LOC_RD(loc_rd), .LOC_RDATA(loc_rdata));
  asc_host_model asc_host_model_inst (.CLK(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Falling edge keeps the pulse counters clear of the edge that launches them
  always @(negedge clk) begin
    cycles++;
    if (resync === 1'b1) n_resync++;
    if (soft_rst === 1'b1) n_soft++;
    if (cycles == 80000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Checks the answer to the previous frame's command
  task automatic fr(input logic [15:0] cmd, input logic [15:0] dat, input int nw, input logic [15:0] e);
    asc_host_model_inst.frame(cmd, dat, nw);
    chk(asc_host_model_inst.rx[0], {8'h00, e, 8'h00});
  endtask : fr

  task automatic lw(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk) begin
      loc_wr    <= 1'b1;
      loc_addr  <= a;
      loc_wdata <= v;
    end
    @(posedge clk) loc_wr <= 1'b0;
  endtask : lw

  task automatic lr(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk) begin
      loc_rd   <= 1'b1;
      loc_addr <= a;
    end
    @(posedge clk) loc_rd <= 1'b0;
    #1 chk(loc_rdata, e);
  endtask : lr

  task automatic push(input logic alt);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      s_valid <= 1'b1;
      s_chan  <= 3'(c);
      s_raw   <= alt ? 26'(c + 16) : raws[c];
    end
    @(posedge clk) s_valid <= 1'b0;
  endtask : push

  task automatic t_local();
    lr(2'h0, 16'h00FF);
    lw(2'h0, 16'h000F);
    lr(2'h0, 16'h000F);
    lw(2'h0, 16'h00FF);
    lw(2'h2, 16'h1111);
    lr(2'h2, 16'h0000);
    lr(2'h1, 16'h0000);
  endtask : t_local

  task automatic t_null();
    asc_host_model_inst.frame(CMD_NULL, 16'h0, 2);
    fr(16'h1234, 16'h0, 2, 16'h0500);
    fr(CMD_NULL, 16'h0, 2, 16'h0500);
  endtask : t_null

  task automatic t_mode();
    fr(CMD_STANDBY, 16'h0, 2, 16'h0500);
    fr(CMD_STANDBY, 16'h0, 2, CMD_STANDBY);
    chk(32'(standby), 32'h1);
    fr(CMD_WAKEUP, 16'h0, 2, CMD_STANDBY);
    chk(32'(standby), 32'h0);
    fr(CMD_WAKEUP, 16'h0, 2, CMD_WAKEUP);
    fr(CMD_NULL, 16'h0, 2, CMD_WAKEUP);
  endtask : t_mode

  task automatic t_lock();
    fr(CMD_LOCK, 16'h0, 2, 16'h0500);
    fr(CMD_STANDBY, 16'h0, 2, CMD_LOCK);
    push(1'b1);
    fr(CMD_UNLOCK_A, 16'h0, 2, 16'h8500);
    chk(32'(standby), 32'h0);
    chk(asc_host_model_inst.rx[1], 32'h10);
    fr(CMD_LOCK, 16'h0, 2, CMD_UNLOCK_A);
    fr(CMD_UNLOCK_B, 16'h0, 2, CMD_LOCK);
    fr(CMD_NULL, 16'h0, 2, CMD_UNLOCK_B);
  endtask : t_lock

  task automatic t_sync();
    lr(2'h1, 16'h00FE);
    @(posedge clk) sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    sync_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(n_resync, 32'h1);
    lr(2'h1, 16'h0000);
  endtask : t_sync

  task automatic t_data();
    push(1'b0);
    push(1'b1);
    repeat (2) @(posedge clk);
    chk(32'(ready_n), 32'h0);
    lr(2'h1, 16'h00FF);
    fr(CMD_NULL, 16'h0, 5, 16'h05FE);
    for (int c = 0; c < 4; c++) chk(asc_host_model_inst.rx[c+1], 32'(codes[c]));
    lr(2'h1, 16'h00FF);
    // Second set straight after the first
    fr(CMD_NULL, 16'h0, 5, 16'h05FF);
    for (int c = 0; c < 4; c++) chk(asc_host_model_inst.rx[c+1], 32'(c + 16));
    lr(2'h1, 16'h00F0);
  endtask : t_data

  task automatic t_regs();
    fr(16'hA100, 16'h0, 2, 16'h05F0);
    fr(16'hA081, 16'h0, 2, MODE_RST);
    fr(CMD_NULL, 16'h0, 3, 16'hE081);
    chk(asc_host_model_inst.rx[1], 32'h0005F000);
    chk(asc_host_model_inst.rx[2], 32'h00051000);
    fr(16'h6180, 16'hBEEF, 2, 16'h05F0);
    fr(16'hA180, 16'h0, 2, 16'h4180);
    fr(16'h6000, 16'h1234, 2, 16'hBEEF);
    fr(CMD_NULL, 16'h0, 2, 16'h407F);
  endtask : t_regs

  task automatic t_reset();
    fr(CMD_RESET, 16'h0, 10, 16'h05F0);
    repeat (200) @(posedge clk);
    chk(n_soft, 32'h1);
    fr(16'hA180, 16'h0, 2, RESP_RESET_OK);
    fr(CMD_RESET, 16'h0, 3, 16'h0000);
    fr(CMD_NULL, 16'h0, 2, RESP_RESET_CUT);
    chk(n_soft, 32'h1);
    // Pulse format through a written mode word
    fr(16'h6100, 16'h0511, 2, 16'h0500);
    push(1'b1);
    repeat (2) @(posedge clk);
    chk(32'(ready_n), 32'h0);
    repeat (12) @(posedge clk);
    chk(32'(ready_n), 32'h1);
  endtask : t_reset

  initial begin
    sys_rst   = 1'b1;
    sync_n    = 1'b1;
    s_valid   = 1'b0;
    s_chan    = 3'h0;
    s_raw     = '0;
    loc_addr  = 2'h0;
    loc_wdata = 16'h0000;
    loc_wr    = 1'b0;
    loc_rd    = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_local();
    t_null();
    t_mode();
    t_lock();
    t_sync();
    t_data();
    t_regs();
    t_reset();
    finish_test();
  end
endmodule : asc_spi_cmd_tb_top
`default_nettype wire
